// ===== hdl/dcq_pkg.sv
// constants shared by the dual clock queue and its storage array
// assumes nothing beyond a SystemVerilog elaborator
package dcq_pkg;
   // storage block size and threshold field widths
   localparam int BLOCK_BITS = 16384;
   localparam int THR_W = 15;
   localparam int EMPTY_FIELD_W = 5;
   localparam logic [EMPTY_FIELD_W-1:0] EMPTY_THR = 5'h00;

   // register byte offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_NFULL_THR = 12'h004;
   localparam logic [11:0] OFS_NEMPTY_THR = 12'h008;
   localparam logic [11:0] OFS_STATUS = 12'h00c;
   localparam logic [11:0] OFS_LEVEL = 12'h010;
   localparam logic [11:0] OFS_LIMITS = 12'h014;

   // control bits
   localparam int CTRL_REGISTERED_OUTPUT_BIT = 0;
   localparam int CTRL_REWIND_BIT = 1;

   // status bits
   localparam int ST_EMPTY_BIT = 0;
   localparam int ST_NEMPTY_BIT = 1;
   localparam int ST_NFULL_BIT = 2;
   localparam int ST_FULL_BIT = 3;
   localparam int ST_WARN_NEMPTY_BIT = 4;
   localparam int ST_WARN_NFULL_BIT = 5;
   localparam int ST_REWIND_BIT = 6;

   // limits register layout
   localparam int LIM_EMPTY_LSB = 16;

   // values after reset
   localparam logic CTRL_REGISTERED_OUTPUT_RST = 1'b0;
   localparam logic [THR_W-1:0] NEMPTY_THR_RST = 15'h0001;
endpackage

// ===== hdl/dcq_array.sv
// storage array of the dual clock queue, cascaded from fixed size blocks
// assumes aligned addresses, one write port on mclk and one combinational read port
`timescale 1ns/1ns
module dcq_array #(
   parameter int UNIT_W = 1,
   parameter int UNITS = 16384,
   parameter int WRAT = 1,
   parameter int RRAT = 1,
   parameter int AW = 14
) (
   // clock
   input wire logic mclk,
   // write port
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WRAT*UNIT_W-1:0] wr_data,
   // read port
   input wire logic [AW-1:0] rd_addr,
   output logic [RRAT*UNIT_W-1:0] rd_data
);
   function automatic int pow2_floor(input int w);
      int p;
      p = 1;
      while (p * 2 <= w) begin
         p = p * 2;
      end
      return p;
   endfunction

   // parity widths share the depth of the next lower power of two
   localparam int BLK_DEPTH = dcq_pkg::BLOCK_BITS / pow2_floor(UNIT_W);
   localparam int DEPTH_PB = (UNITS < BLK_DEPTH) ? UNITS : BLK_DEPTH;
   localparam int BLOCKS = (UNITS + DEPTH_PB - 1) / DEPTH_PB;

   // contents are never reset: pointers, flags and the read word registers are
   logic [UNIT_W-1:0] mem [BLOCKS][DEPTH_PB];

   // upper address bits act as block select when cascaded in depth
   always_ff @(posedge mclk) begin
      if (wr_en) begin
         for (int i = 0; i < WRAT; i++) begin
            mem[(int'(wr_addr) + i) / DEPTH_PB][(int'(wr_addr) + i) % DEPTH_PB] <=
               wr_data[i*UNIT_W +: UNIT_W];
         end
      end
   end

   always_comb begin
      rd_data = '0;
      for (int i = 0; i < RRAT; i++) begin
         rd_data[i*UNIT_W +: UNIT_W] =
            mem[(int'(rd_addr) + i) / DEPTH_PB][(int'(rd_addr) + i) % DEPTH_PB];
      end
   end
endmodule

// ===== hdl/dcq_queue.sv
// dual clock queue: write and read clients on their own clocks, apb registers
// assumes client clocks far slower than mclk; clients drive on their rising edges
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module dcq_queue #(
   parameter int WR_WIDTH = 1,
   parameter int RD_WIDTH = 1,
   parameter int WR_DEPTH = 16384,
   parameter bit RESET_ASYNC = 1'b1
) (
   // system
   input wire logic mclk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // writing client
   input wire logic write_side_clock,
   input wire logic user_write_strobe,
   input wire logic [WR_WIDTH-1:0] write_word,
   // reading client
   input wire logic read_side_clock,
   input wire logic user_read_strobe,
   output logic [RD_WIDTH-1:0] read_word,
   // flags
   output logic full_flag,
   output logic nearly_full_flag,
   output logic empty_flag,
   output logic nearly_empty_flag
);
   localparam int UNIT_W = (WR_WIDTH < RD_WIDTH) ? WR_WIDTH : RD_WIDTH;
   localparam int WRAT = WR_WIDTH / UNIT_W;
   localparam int RRAT = RD_WIDTH / UNIT_W;
   localparam int UNITS = WR_DEPTH * WRAT;
   localparam int AW = $clog2(UNITS);
   localparam int TW = dcq_pkg::THR_W;
   localparam logic [TW-1:0] FULL_THR = TW'(UNITS - 1);
   localparam logic [TW-1:0] NFULL_THR_RST = TW'(UNITS - 2);
   localparam logic [TW:0] WSTEP = (TW+1)'(WRAT);
   localparam logic [TW:0] RSTEP = (TW+1)'(RRAT);

   function automatic bit legal_width(input int w);
      return (w == 1) || (w == 2) || (w == 4) || (w == 9) || (w == 18) || (w == 36);
   endfunction

   // fill level in narrow units, widened for threshold compares
   function automatic logic [TW:0] fill_of(input logic [AW-1:0] a, input logic [AW-1:0] b);
      logic [AW-1:0] d;
      d = a - b;
      return (TW+1)'(d);
   endfunction

   if (!legal_width(WR_WIDTH) || !legal_width(RD_WIDTH)) begin : g_bad_width
      $error("port width must be 1, 2, 4, 9, 18 or 36");
   end
   if ((WRAT * UNIT_W != WR_WIDTH) || (RRAT * UNIT_W != RD_WIDTH) ||
       ((WRAT & (WRAT - 1)) != 0) || ((RRAT & (RRAT - 1)) != 0)) begin : g_bad_ratio
      $error("port widths must differ by a power of two");
   end
   if ((WR_DEPTH & (WR_DEPTH - 1)) != 0 || UNITS < 4 || AW > TW) begin : g_bad_depth
      $error("depth must be a power of two within the threshold field");
   end

   // pin synchronisers; first stages feed only the second stages
   logic wclk_s1_ff, wclk_s2_ff, wclk_s3_ff;
   logic wstb_s1_ff, wstb_s2_ff, wstb_cap_ff;
   logic [WR_WIDTH-1:0] wdat_s1_ff, wdat_s2_ff, wdat_cap_ff;
   logic rclk_s1_ff, rclk_s2_ff, rclk_s3_ff;
   logic rstb_s1_ff, rstb_s2_ff, rstb_cap_ff;

   // clock samplers run through reset: held at zero they would report a false
   // rising edge on release, and synchronous reset mode needs real edges then
   always_ff @(posedge mclk) begin
      wclk_s1_ff <= write_side_clock;
      wclk_s2_ff <= wclk_s1_ff;
      wclk_s3_ff <= wclk_s2_ff;
      rclk_s1_ff <= read_side_clock;
      rclk_s2_ff <= rclk_s1_ff;
      rclk_s3_ff <= rclk_s2_ff;
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wstb_s1_ff <= 1'b0;
         wstb_s2_ff <= 1'b0;
         wdat_s1_ff <= '0;
         wdat_s2_ff <= '0;
         rstb_s1_ff <= 1'b0;
         rstb_s2_ff <= 1'b0;
      end else begin
         wstb_s1_ff <= user_write_strobe;
         wstb_s2_ff <= wstb_s1_ff;
         wdat_s1_ff <= write_word;
         wdat_s2_ff <= wdat_s1_ff;
         rstb_s1_ff <= user_read_strobe;
         rstb_s2_ff <= rstb_s1_ff;
      end
   end

   logic wr_tick, rd_tick, wr_fall, rd_fall;
   assign wr_tick = wclk_s2_ff && !wclk_s3_ff;
   assign rd_tick = rclk_s2_ff && !rclk_s3_ff;
   assign wr_fall = !wclk_s2_ff && wclk_s3_ff;
   assign rd_fall = !rclk_s2_ff && rclk_s3_ff;

   // clients change their pins just after a rising edge, so mid period sampling
   // holds the values that the next rising edge must see
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wstb_cap_ff <= 1'b0;
         wdat_cap_ff <= '0;
         rstb_cap_ff <= 1'b0;
      end else begin
         if (wr_fall) begin
            wstb_cap_ff <= wstb_s2_ff;
            wdat_cap_ff <= wdat_s2_ff;
         end
         if (rd_fall) begin
            rstb_cap_ff <= rstb_s2_ff;
         end
      end
   end

   // reset acts at once, or only on an edge of the side's own clock
   logic wr_rst, rd_rst;
   assign wr_rst = !nrst && (RESET_ASYNC || wr_tick);
   assign rd_rst = !nrst && (RESET_ASYNC || rd_tick);

   // software registers
   logic ctrl_registered_output_ff, rewind_pend_ff;
   logic [TW-1:0] nfull_thr_ff, nempty_thr_ff;
   logic [TW-1:0] nfull_eff, nempty_eff;
   logic warn_nfull, warn_nempty;

   // out of range thresholds are clamped rather than refused, and shown in status
   assign warn_nfull = (nfull_thr_ff >= FULL_THR);
   assign warn_nempty = (nempty_thr_ff == TW'(dcq_pkg::EMPTY_THR));
   assign nfull_eff = warn_nfull ? FULL_THR : nfull_thr_ff;
   assign nempty_eff = warn_nempty ? TW'(dcq_pkg::EMPTY_THR) : nempty_thr_ff;

   // write side state
   logic [AW-1:0] wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
   logic full_ff, nfull_ff, empty_ff, nempty_ff;
   logic wr_accept, int_rd;
   logic [TW:0] wr_nxt_fill, rd_nxt_fill;

   // a refused strobe still re-evaluates full, so full clears only on a strobed edge
   assign wr_accept = wr_tick && wstb_cap_ff && !full_ff && !wr_rst;
   assign nxt_wr_ptr = wr_accept ? wr_ptr_ff + AW'(WRAT) : wr_ptr_ff;
   assign wr_nxt_fill = fill_of(nxt_wr_ptr, rd_ptr_ff);

   // the write pointer only moves on strobed write edges, so it is the
   // write clock copy of not empty that the read side samples
   always_ff @(posedge mclk) begin
      if (wr_rst) begin
         wr_ptr_ff <= '0;
         full_ff <= 1'b0;
         nfull_ff <= 1'b0;
      end else if (wr_tick) begin
         if (wstb_cap_ff) begin
            wr_ptr_ff <= nxt_wr_ptr;
            // judged with the next word in mind: capacity is one write word short of depth
            full_ff <= (wr_nxt_fill + WSTEP > {1'b0, FULL_THR});
         end
         nfull_ff <= (wr_nxt_fill >= {1'b0, nfull_eff});
      end
   end

   // read side state
   logic [RD_WIDTH-1:0] arr_rd_data, arr_q_ff, read_word_ff;

   assign int_rd = rd_tick && rstb_cap_ff && !empty_ff && !rd_rst;
   assign nxt_rd_ptr = rewind_pend_ff ? '0 : (int_rd ? rd_ptr_ff + AW'(RRAT) : rd_ptr_ff);
   assign rd_nxt_fill = fill_of(wr_ptr_ff, nxt_rd_ptr);

   always_ff @(posedge mclk) begin
      if (rd_rst) begin
         rd_ptr_ff <= '0;
         empty_ff <= 1'b1;
         nempty_ff <= 1'b1;
      end else if (rd_tick) begin
         rd_ptr_ff <= nxt_rd_ptr;
         // empty only falls on a strobed edge: the read clock stage of not empty
         if (rstb_cap_ff) begin
            empty_ff <= (rd_nxt_fill < RSTEP);
         end
         nempty_ff <= (rd_nxt_fill <= {1'b0, nempty_eff});
      end
   end

   // array stage loads on internal read; output stage is selectable
   // registered mode trades one more strobed edge for a short output path
   always_ff @(posedge mclk) begin
      if (rd_rst) begin
         arr_q_ff <= '0;
         read_word_ff <= '0;
      end else if (rd_tick) begin
         if (int_rd) begin
            arr_q_ff <= arr_rd_data;
         end
         if (!ctrl_registered_output_ff && int_rd) begin
            read_word_ff <= arr_rd_data;
         end else if (ctrl_registered_output_ff && rstb_cap_ff) begin
            read_word_ff <= arr_q_ff;
         end
      end
   end

   dcq_array #(
      .UNIT_W(UNIT_W),
      .UNITS(UNITS),
      .WRAT(WRAT),
      .RRAT(RRAT),
      .AW(AW)
   ) u_array (
      .mclk(mclk),
      .wr_en(wr_accept),
      .wr_addr(wr_ptr_ff),
      .wr_data(wdat_cap_ff),
      .rd_addr(rd_ptr_ff),
      .rd_data(arr_rd_data)
   );

   // apb slave: one wait free access cycle, answer registered in setup
   // read data is a copy taken at setup, so a flag may be one cycle stale
   logic [31:0] prdata_ff, rd_mux;
   logic pready_ff, pslverr_ff, addr_ok, apb_wr;
   logic [31:0] status_word;

   always_comb begin
      status_word = '0;
      status_word[dcq_pkg::ST_EMPTY_BIT] = empty_ff;
      status_word[dcq_pkg::ST_NEMPTY_BIT] = nempty_ff;
      status_word[dcq_pkg::ST_NFULL_BIT] = nfull_ff;
      status_word[dcq_pkg::ST_FULL_BIT] = full_ff;
      status_word[dcq_pkg::ST_WARN_NEMPTY_BIT] = warn_nempty;
      status_word[dcq_pkg::ST_WARN_NFULL_BIT] = warn_nfull;
      status_word[dcq_pkg::ST_REWIND_BIT] = rewind_pend_ff;
   end

   always_comb begin
      addr_ok = 1'b1;
      rd_mux = '0;
      unique case (paddr)
         dcq_pkg::OFS_CTRL: rd_mux[dcq_pkg::CTRL_REGISTERED_OUTPUT_BIT] = ctrl_registered_output_ff;
         dcq_pkg::OFS_NFULL_THR: rd_mux = 32'(nfull_thr_ff);
         dcq_pkg::OFS_NEMPTY_THR: rd_mux = 32'(nempty_thr_ff);
         dcq_pkg::OFS_STATUS: rd_mux = status_word;
         dcq_pkg::OFS_LEVEL: rd_mux = 32'(fill_of(wr_ptr_ff, rd_ptr_ff));
         dcq_pkg::OFS_LIMITS: begin
            rd_mux = 32'(FULL_THR);
            rd_mux[dcq_pkg::LIM_EMPTY_LSB +: dcq_pkg::EMPTY_FIELD_W] = dcq_pkg::EMPTY_THR;
         end
         default: addr_ok = 1'b0;
      endcase
   end

   assign apb_wr = psel && penable && pready_ff && pwrite && !pslverr_ff;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= '0;
      end else begin
         pready_ff <= psel && !penable;
         if (psel && !penable) begin
            pslverr_ff <= !addr_ok;
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
         end else begin
            pslverr_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ctrl_registered_output_ff <= dcq_pkg::CTRL_REGISTERED_OUTPUT_RST;
         nfull_thr_ff <= NFULL_THR_RST;
         nempty_thr_ff <= dcq_pkg::NEMPTY_THR_RST;
      end else if (apb_wr) begin
         if (paddr == dcq_pkg::OFS_CTRL) begin
            ctrl_registered_output_ff <= pwdata[dcq_pkg::CTRL_REGISTERED_OUTPUT_BIT];
         end
         if (paddr == dcq_pkg::OFS_NFULL_THR) begin
            nfull_thr_ff <= pwdata[TW-1:0];
         end
         if (paddr == dcq_pkg::OFS_NEMPTY_THR) begin
            nempty_thr_ff <= pwdata[TW-1:0];
         end
      end
   end

   // a rewind request made on the edge that consumes the last one still wins
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rewind_pend_ff <= 1'b0;
      end else if (apb_wr && paddr == dcq_pkg::OFS_CTRL &&
                   pwdata[dcq_pkg::CTRL_REWIND_BIT]) begin
         rewind_pend_ff <= 1'b1;
      end else if (rd_tick) begin
         rewind_pend_ff <= 1'b0;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign read_word = read_word_ff;
   assign full_flag = full_ff;
   assign nearly_full_flag = nfull_ff;
   assign empty_flag = empty_ff;
   assign nearly_empty_flag = nempty_ff;
endmodule

// ===== verification/dcq_queue_assertions.sv
// port checker for the dual clock queue
// assumes mclk samples both client clocks; bound to the top at the foot
`timescale 1ns/1ns
module dcq_queue_chk #(
   parameter int RD_WIDTH = 1
) (
   // system and apb
   input wire logic mclk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // client side
   input wire logic write_side_clock,
   input wire logic read_side_clock,
   input wire logic [RD_WIDTH-1:0] read_word,
   input wire logic full_flag,
   input wire logic nearly_full_flag,
   input wire logic empty_flag,
   input wire logic nearly_empty_flag
);
   // cycles since a client clock rise, saturating so idle stretches stay cheap
   logic wprev_ff, rprev_ff;
   logic [2:0] wcnt_ff, rcnt_ff;
   always_ff @(posedge mclk) begin
      wprev_ff <= write_side_clock;
      rprev_ff <= read_side_clock;
   end
   always_ff @(posedge mclk) begin
      if (!nrst) wcnt_ff <= 3'h7;
      else if (write_side_clock && !wprev_ff) wcnt_ff <= 3'h0;
      else if (wcnt_ff != 3'h7) wcnt_ff <= wcnt_ff + 3'h1;
   end
   always_ff @(posedge mclk) begin
      if (!nrst) rcnt_ff <= 3'h7;
      else if (read_side_clock && !rprev_ff) rcnt_ff <= 3'h0;
      else if (rcnt_ff != 3'h7) rcnt_ff <= rcnt_ff + 3'h1;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_one_access;
      pready ##1 !pready;
   endsequence
   property p_answer;
      s_setup |=> s_one_access;
   endproperty
   property p_ready_cause;
      pready |-> penable && $past(psel && !penable);
   endproperty
   property p_err;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   property p_reset_state;
      $rose(nrst) |-> empty_flag && nearly_empty_flag && !full_flag && !nearly_full_flag
         && read_word == '0;
   endproperty
   property p_full_wclk;
      $changed(full_flag) && $past(nrst) |-> wcnt_ff <= 3'h6;
   endproperty
   property p_nfull_wclk;
      (wcnt_ff == 3'h7) && $past(nrst) |-> $stable(nearly_full_flag);
   endproperty
   property p_empty_rclk;
      $changed(empty_flag) && $past(nrst) |-> rcnt_ff <= 3'h6;
   endproperty
   property p_nempty_rclk;
      (rcnt_ff == 3'h7) && $past(nrst) |-> $stable(nearly_empty_flag);
   endproperty
   property p_word_rclk;
      $changed(read_word) && $past(nrst) |-> rcnt_ff >= 3'h1 && rcnt_ff <= 3'h6;
   endproperty
   a_answer: assert property (p_answer) else $error("setup not answered by one access");
   a_ready_cause: assert property (p_ready_cause) else $error("pready without setup");
   a_err: assert property (p_err) else $error("pslverr without pready or with data");
   a_reset_state: assert property (p_reset_state)
      else $error("state after reset wrong");
   a_full_wclk: assert property (p_full_wclk)
      else $error("full flag moved off the write clock");
   a_nfull_wclk: assert property (p_nfull_wclk)
      else $error("nearly full flag moved off the write clock");
   a_empty_rclk: assert property (p_empty_rclk)
      else $error("empty flag moved off the read clock");
   a_nempty_rclk: assert property (p_nempty_rclk)
      else $error("nearly empty flag moved off the read clock");
   a_word_rclk: assert property (p_word_rclk)
      else $error("read word moved off the read clock");
endmodule
bind dcq_queue dcq_queue_chk #(.RD_WIDTH(RD_WIDTH)) u_chk (.mclk(mclk), .nrst(nrst), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .write_side_clock(write_side_clock), .read_side_clock(read_side_clock),
   .read_word(read_word), .full_flag(full_flag), .nearly_full_flag(nearly_full_flag),
   .empty_flag(empty_flag), .nearly_empty_flag(nearly_empty_flag));

// ===== verification/dcq_client.sv
// writer and reader client model on free running 125 ns clocks
// assumes requests change on mclk edges, away from client edges
`timescale 1ns/1ns
module dcq_client #(
   parameter int W = 9
) (
   // requests from the bench
   input wire logic wr_req,
   input wire logic [W-1:0] wr_val,
   input wire logic rd_req,
   // client pins
   output logic write_side_clock,
   output logic user_write_strobe,
   output logic [W-1:0] write_word,
   output logic read_side_clock,
   output logic user_read_strobe
);
   initial begin
      write_side_clock = 1'b0;
      read_side_clock = 1'b0;
      user_write_strobe = 1'b0;
      user_read_strobe = 1'b0;
      write_word = '0;
   end
   always begin
      #62 write_side_clock = 1'b1;
      #63 write_side_clock = 1'b0;
   end
   always begin
      #40 read_side_clock = 1'b1;
      #62 read_side_clock = 1'b0;
      #23;
   end
   // data without strobe toggles so a stale word is never mistaken for a good one
   always @(posedge write_side_clock) begin
      user_write_strobe <= wr_req;
      write_word <= wr_req ? wr_val : ~write_word;
   end
   always @(posedge read_side_clock) begin
      user_read_strobe <= rd_req;
   end
endmodule

// ===== verification/dcq_queue_test.sv
// self-checking bench for the dual clock queue
// assumes the client model and the bound port checker
`timescale 1ns/1ns
module dcq_queue_test;
   localparam int W = 9;
   logic mclk, nrst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rnd;
   logic wclk, wstb, rclk, rstb, wr_req, rd_req, ff, nff, ef, nef, rmode, pend, full_m;
   logic [W-1:0] wword, rword, wr_val;
   logic [32:0] aq[$];
   logic [W-1:0] wq[$], sv[$];
   int err_count, tests_run;
   dcq_queue #(.WR_WIDTH(W), .RD_WIDTH(W), .WR_DEPTH(16)) u_dut (.mclk(mclk), .nrst(nrst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .write_side_clock(wclk),
      .user_write_strobe(wstb), .write_word(wword), .read_side_clock(rclk),
      .user_read_strobe(rstb), .read_word(rword), .full_flag(ff), .nearly_full_flag(nff),
      .empty_flag(ef), .nearly_empty_flag(nef));
   dcq_client #(.W(W)) u_cli (.wr_req(wr_req), .wr_val(wr_val), .rd_req(rd_req),
      .write_side_clock(wclk), .user_write_strobe(wstb), .write_word(wword),
      .read_side_clock(rclk), .user_read_strobe(rstb));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk_v(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic chk_w(input logic [W-1:0] exp, input logic [W-1:0] got);
      chk_v("read_word", 32'(exp), 32'(got));
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] exp);
      int n;
      if (!wr) aq.push_back(exp);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         err_count++;
         test_done();
      end
   endtask
   // apb read results, taken at the edge that closes the access
   always @(posedge mclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         chk_v("prdata", aq[0][31:0], prdata);
         chk_v("pslverr", 32'(aq[0][32]), 32'(pslverr));
         void'(aq.pop_front());
      end
   end
   // writer model: full only re-evaluates on a strobed edge
   always @(posedge wclk) begin
      if (wstb === 1'b1) begin
         if (!full_m) wq.push_back(wword);
         full_m = (wq.size() >= 15);
      end
   end
   // reader: a word moves when strobe and not empty at the edge, one edge later if registered
   always @(posedge rclk) begin
      logic s, e;
      s = rstb;
      e = ef;
      repeat (8) @(posedge mclk);
      if (s === 1'b1) begin
         if (rmode ? pend : !e) begin
            if (wq.size() == 0) chk_v("spare_read", 32'h0, 32'h1);
            else chk_w(wq.pop_front(), rword);
         end
         pend = !e;
      end
   end
   task automatic do_reset();
      @(posedge mclk);
      nrst <= 1'b0;
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      wq.delete();
      pend = 1'b0;
      rmode = 1'b0;
      full_m = 1'b0;
      repeat (20) @(posedge mclk);
   endtask
   task automatic wr_n(input int n);
      repeat (n) begin
         @(posedge mclk);
         rnd = xs(rnd);
         wr_req <= 1'b1;
         wr_val <= rnd[W-1:0];
         @(posedge wclk);
      end
      @(posedge mclk);
      wr_req <= 1'b0;
      @(posedge wclk);
      repeat (8) @(posedge mclk);
   endtask
   task automatic drain();
      int n;
      @(posedge mclk);
      rd_req <= 1'b1;
      n = 0;
      while (wq.size() > 0 && n < 60) begin
         @(posedge rclk);
         n++;
      end
      @(posedge mclk);
      rd_req <= 1'b0;
      repeat (2) @(posedge rclk);
      repeat (8) @(posedge mclk);
      if (n >= 60) begin
         err_count++;
         test_done();
      end
   endtask
   initial begin
      #900000;
      err_count++;
      test_done();
   end
   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      wr_req = 1'b0;
      wr_val = '0;
      rd_req = 1'b0;
      rnd = 32'ha59f;
      err_count = 0;
      tests_run = 0;
      do_reset();
      chk_v("flags", 32'h3, {28'h0, ff, nff, nef, ef});
      apb(1'b0, 12'h00c, 32'h0, 33'h3);
      apb(1'b0, 12'h014, 32'h0, 33'hf);
      apb(1'b0, 12'h008, 32'h0, 33'h1);
      apb(1'b0, 12'h018, 32'h0, 33'h100000000);
      apb(1'b1, 12'h004, 32'hf, 33'h0);
      apb(1'b1, 12'h008, 32'h0, 33'h0);
      apb(1'b0, 12'h00c, 32'h0, 33'h33);
      apb(1'b1, 12'h004, 32'h4, 33'h0);
      apb(1'b1, 12'h008, 32'h2, 33'h0);
      apb(1'b0, 12'h00c, 32'h0, 33'h3);
      wr_n(3);
      chk_v("nearly_full", 32'h0, 32'(nff));
      repeat (16) @(posedge mclk);
      chk_v("nearly_empty", 32'h0, 32'(nef));
      chk_v("empty", 32'h1, 32'(ef));
      wr_n(1);
      chk_v("nearly_full", 32'h1, 32'(nff));
      wr_n(12);
      chk_v("full", 32'(full_m), 32'(ff));
      apb(1'b0, 12'h010, 32'h0, 33'hf);
      drain();
      chk_v("empty", 32'h1, 32'(ef));
      chk_v("full", 32'(full_m), 32'(ff));
      wr_n(1);
      chk_v("full", 32'(full_m), 32'(ff));
      apb(1'b0, 12'h010, 32'h0, 33'h0);
      wr_n(2);
      do_reset();
      chk_v("flags", 32'h3, {28'h0, ff, nff, nef, ef});
      apb(1'b0, 12'h010, 32'h0, 33'h0);
      wr_n(3);
      sv = wq;
      drain();
      apb(1'b1, 12'h000, 32'h2, 33'h0);
      apb(1'b0, 12'h000, 32'h0, 33'h0);
      repeat (30) @(posedge mclk);
      wq = sv;
      drain();
      apb(1'b1, 12'h000, 32'h1, 33'h0);
      rmode = 1'b1;
      wr_n(2);
      drain();
      test_done();
   end
endmodule
